// ===== bench/tape_control_break_sequencer_test.sv
// self-checking bench for the tape control break sequencer
`timescale 1ns/1ps
`default_nettype none
module tape_control_break_sequencer_test;
  logic                    clk_sys, srst, ce, brk_ack, wr_en_q, mark_route_q, irq_q;
  tcbs_pkg::tcbs_pio_req_s pio_req;
  tcbs_pkg::tcbs_pio_rsp_s pio_rsp_q;
  tcbs_pkg::tcbs_brk_s     brk_q;
  tcbs_pkg::tcbs_pins_s    tp;
  logic [11:0]             brk_rdata, rd;
  logic [2:0]              unit_sel_q, wr_line_q;
  logic [7:0]              go_q, dir_q;
  logic [3:0]              lag;
  int                      fail_count, n_tests;
  tcbs_sequencer DUT (.clk_sys(clk_sys), .srst(srst), .ce(ce), .pio_req(pio_req),
    .pio_rsp_q(pio_rsp_q), .brk_ack(brk_ack), .brk_rdata(brk_rdata), .brk_q(brk_q),
    .tp_pins(tp), .unit_sel_q(unit_sel_q), .go_q(go_q), .dir_q(dir_q), .wr_en_q(wr_en_q),
    .wr_line_q(wr_line_q), .mark_route_q(mark_route_q), .irq_q(irq_q));
  tcbs_mem_model mem (.clk_sys(clk_sys), .srst(srst), .brk(brk_q), .lag(lag),
    .brk_ack(brk_ack), .brk_rdata(brk_rdata));
  // free-running system clock
  always #4 clk_sys = ~clk_sys;
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one programmed transfer; answer lands the cycle after the strobe
  task automatic pio(input tcbs_pkg::tcbs_op_e op, input logic [11:0] ac);
    @(posedge clk_sys);
    #1 pio_req = '{stb: 1'b1, op: op, ac: ac};
    @(posedge clk_sys);
    #1 pio_req.stb = 1'b0;
    chk(pio_rsp_q.done, 1'b1);
    rd = pio_rsp_q.rdata;
  endtask
  function automatic logic [11:0] mk_a(logic [2:0] u, logic d, logic g, logic m, logic [2:0] f);
    return {u, d, g, m, f, 3'h7}; // interrupt enable on, both flags cleared
  endfunction
  task automatic load_a(input logic [11:0] a);
    pio(tcbs_pkg::TCBS_OP_CLRLD_A, a);
  endtask
  // strobes are slow against the clock since the pins pass a synchroniser
  task automatic word_in(input logic [11:0] w);
    for (int i = 3; i >= 0; i--)
    begin
      tp.line = w[i*3 +: 3];
      tp.line_stb = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 tp.line_stb = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic wait_brk;
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 400; i++)
    begin
      @(posedge clk_sys);
      #1 if (brk_q.req === 1'b1) seen = 1'b1;
      if (seen && brk_q.req === 1'b0) return;
    end
    chk({seen, brk_q.req}, 2'h2);
  endtask
  task automatic t_status;
    load_a(mk_a(3'h2, 1'b1, 1'b1, 1'b1, 3'h0));
    @(posedge clk_sys);
    #1 chk(unit_sel_q, 3'h2);
    chk({go_q[2], dir_q[2]}, 2'h3);
    pio(tcbs_pkg::TCBS_OP_RD_A, 12'h000);
    chk(rd, 12'h5c4);
    for (int k = 0; k < 2; k++)
    begin
      load_a(mk_a(3'h0, 1'b0, 1'b0, 1'b0, 3'h0));
      repeat (3) @(posedge clk_sys);
      pio(tcbs_pkg::TCBS_OP_RD_B, 12'h000);
      chk(rd[8], 1'b0);
      load_a(mk_a(3'h0, 1'b0, 1'b0, 1'b0, k ? 3'h7 : 3'h6));
      repeat (3) @(posedge clk_sys);
      pio(tcbs_pkg::TCBS_OP_RD_B, 12'h000);
      chk({rd[11], rd[8]}, 2'h3);
    end
    // switch on plus timing-mark function: legal, routed, writing
    tp.track_write_setting_sw = 1'b1;
    load_a(mk_a(3'h0, 1'b0, 1'b1, 1'b0, 3'h6));
    repeat (4) @(posedge clk_sys);
    #1 chk({mark_route_q, wr_en_q}, 2'h3);
    pio(tcbs_pkg::TCBS_OP_RD_B, 12'h000);
    chk(rd[8], 1'b0);
    tp.track_write_setting_sw = 1'b0;
    load_a(mk_a(3'h0, 1'b0, 1'b0, 1'b0, 3'h0));
  endtask
  task automatic t_endzone;
    load_a(mk_a(3'h3, 1'b0, 1'b1, 1'b0, 3'h0));
    tp.end_zone[5] = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 chk(go_q[3], 1'b1);
    tp.end_zone[3] = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 chk(go_q[3], 1'b0);
    pio(tcbs_pkg::TCBS_OP_RD_B, 12'h000);
    chk(rd[9], 1'b1);
    tp.end_zone = 8'h00;
  endtask
  task automatic t_search(input logic m, input logic [11:0] cnt, input logic ex);
    mem.mem[15'h0fec] = cnt;
    mem.mem[15'h0fed] = 12'h100;
    lag = 4'h0;
    load_a(mk_a(3'h1, 1'b0, 1'b1, m, 3'h1));
    tp.blknum_zone = 1'b1;
    word_in(cnt ^ 12'h321);
    tp.blknum_zone = 1'b0;
    wait_brk;
    chk(mem.mem[15'h0100], cnt ^ 12'h321);
    chk(mem.mem[15'h0fed], 12'h100);
    chk(mem.mem[15'h0fec], 12'(cnt + 12'h001));
    repeat (4) @(posedge clk_sys);
    #1 chk(irq_q, ex);
    pio(tcbs_pkg::TCBS_OP_SKIP, 12'h000);
    chk(pio_rsp_q.skip, ex);
  endtask
  task automatic t_read;
    pio(tcbs_pkg::TCBS_OP_LD_B, 12'h028);
    pio(tcbs_pkg::TCBS_OP_RD_B, 12'h000);
    chk(rd[5:3], 3'h5);
    mem.mem[15'h0fec] = 12'h010;
    mem.mem[15'h0fed] = 12'h1ff;
    lag = 4'h9;
    load_a(mk_a(3'h4, 1'b0, 1'b1, 1'b0, 3'h2));
    tp.data_zone = 1'b1;
    word_in(12'ha5c);
    tp.data_zone = 1'b0;
    wait_brk;
    chk(mem.mem[15'h5200], 12'ha5c);
    chk(mem.mem[15'h0fed], 12'h200);
    chk(mem.mem[15'h0fec], 12'h011);
    tp.chk_zone = 1'b1;
    word_in(12'h035); // equivalence sum of the one data word, seed all ones
    tp.chk_zone = 1'b0;
    repeat (8) @(posedge clk_sys);
    pio(tcbs_pkg::TCBS_OP_RD_B, 12'h000);
    chk(rd[0], 1'b1);
    chk(rd[7], 1'b0);
  endtask
  // watchdog well past the few hundred cycles the scenarios need
  initial
  begin
    #(8 * 40000);
    fail_count++;
    close_out;
  end
  // main sequence
  initial
  begin
    clk_sys = 1'b0;
    srst = 1'b1;
    ce = 1'b1;
    lag = 4'h0;
    pio_req = '0;
    tp = '0;
    fail_count = 0;
    n_tests = 0;
    repeat (12) @(posedge clk_sys);
    #1 srst = 1'b0;
    pio(tcbs_pkg::TCBS_OP_RD_A, 12'h000);
    chk(rd, 12'h000);
    pio(tcbs_pkg::TCBS_OP_RD_B, 12'h000);
    chk({rd, go_q}, 20'h0);
    t_status;
    t_endzone;
    t_search(1'b0, 12'h005, 1'b1);
    t_search(1'b1, 12'hffe, 1'b0);
    t_search(1'b1, 12'hfff, 1'b1);
    t_read;
    close_out;
  end
endmodule
`default_nettype wire

// ===== bench/tcbs_mem_model.sv
// behavioural processor memory answering the three-cycle break channel
`timescale 1ns/1ps
`default_nettype none
module tcbs_mem_model (
  input  wire logic                clk_sys,
  input  wire logic                srst,
  input  wire tcbs_pkg::tcbs_brk_s brk,
  input  wire logic [3:0]          lag,
  output var  logic                brk_ack,
  output var  logic [11:0]         brk_rdata
);
  logic [11:0] mem [0:32767];
  logic [3:0]  wait_q;
  // one ack per step, then a gap so the next step settles first
  // plain clocked process: the bench preloads the array between breaks
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      brk_ack <= 1'b0;
      wait_q <= 4'h0;
      brk_rdata <= 12'h5a5;
    end
    else if (brk_ack || !brk.req)
    begin
      brk_ack <= 1'b0;
      wait_q <= 4'h0;
      brk_rdata <= ~brk_rdata; // released bus inverts the word every cycle instead of holding it
    end
    else if (wait_q >= lag)
    begin
      brk_ack <= 1'b1;
      brk_rdata <= mem[brk.addr];
      if (brk.wr)
        mem[brk.addr] <= brk.wdata;
    end
    else
    begin
      wait_q <= wait_q + 4'h1;
      brk_rdata <= ~brk_rdata;
    end
  end
endmodule
`default_nettype wire

// ===== core/tcbs_defs.svh
// constant definitions for the tape control break sequencer
`ifndef TCBS_DEFS_SVH
`define TCBS_DEFS_SVH
// fixed control-word locations in field 0 (octal 7754 and 7755)
`define TCBS_CNT_ADDR 12'hfec
`define TCBS_PTR_ADDR 12'hfed
`define TCBS_FIELD0 3'h0
// first status register fields
`define TCBS_A_UNIT 11:9
`define TCBS_A_DIR 8
`define TCBS_A_GO 7
`define TCBS_A_MODE 6
`define TCBS_A_FUNC 5:3
`define TCBS_A_IE 2
`define TCBS_A_CLR_ERR 1
`define TCBS_A_CLR_DONE 0
`define TCBS_A_LOAD_MASK 12'hffc
`define TCBS_A_RESET 12'h000
// second status register fields
`define TCBS_B_ERR 11
`define TCBS_B_ENDZ 9
`define TCBS_B_SEL 8
`define TCBS_B_PAR 7
`define TCBS_B_TIM 6
`define TCBS_B_FIELD 5:3
`define TCBS_B_DRQ 1
`define TCBS_B_DONE 0
// break answer limit: 17 us plus 30 percent, rounded down at 8 ns
`define TCBS_BRK_T_NS 17000
`define TCBS_BRK_TOL_PCT 30
`define TCBS_CLK_NS 8
`define TCBS_BRK_TMO_CYC ((`TCBS_BRK_T_NS * (100 + `TCBS_BRK_TOL_PCT)) / (100 * `TCBS_CLK_NS))
`define TCBS_TMO_W 12
// four three-bit lines per word, check character seed
`define TCBS_LINE_LAST 2'h3
`define TCBS_CHK_INIT 6'h3f
`endif

// ===== core/tcbs_line_packer.sv
// three-bit line shifter and block check character accumulator
`include "tcbs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tcbs_line_packer (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        line_stb,
  input  wire logic [2:0]  line_in,
  input  wire logic        wr_mode,
  input  wire logic        load,
  input  wire logic [11:0] load_word,
  input  wire logic        acc_stb,
  input  wire logic        acc_clr,
  input  wire logic [11:0] acc_word,
  output var  logic [11:0] word_q,
  output var  logic        word_stb_q,
  output var  logic [2:0]  line_out_q,
  output var  logic [5:0]  chk_q
);
  logic [1:0]  pos_q;
  wire  [11:0] shifted;
  wire  [5:0]  folded;

  // writes shift zeros in behind the outgoing line
  assign shifted = {word_q[8:0], wr_mode ? 3'h0 : line_in};
  assign folded  = acc_word[11:6] ^ acc_word[5:0];

  // load wins over a line strobe; the break always lands between lines
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      word_q     <= 12'h000;
      pos_q      <= 2'h0;
      word_stb_q <= 1'b0;
      line_out_q <= 3'h0;
      chk_q      <= `TCBS_CHK_INIT;
    end
    else if (ce)
    begin
      word_stb_q <= line_stb && (pos_q == `TCBS_LINE_LAST);
      if (load)
        word_q <= load_word;
      else if (line_stb)
      begin
        word_q     <= shifted;
        line_out_q <= word_q[11:9];
        pos_q      <= pos_q + 2'h1;
      end
      // equivalence sum of both word halves
      if (acc_clr)
        chk_q <= `TCBS_CHK_INIT;
      else if (acc_stb)
        chk_q <= ~(chk_q ^ folded);
    end
  end
endmodule
`default_nettype wire

// ===== core/tcbs_pkg.sv
// types shared by the tape control break sequencer
package tcbs_pkg;
  typedef enum logic [2:0] {
    TCBS_F_MOVE, TCBS_F_SEARCH, TCBS_F_RD_DATA, TCBS_F_RD_ALL,
    TCBS_F_WR_DATA, TCBS_F_WR_ALL, TCBS_F_WR_TM
  } tcbs_func_e;
  typedef enum logic [2:0] {
    TCBS_OP_RD_A, TCBS_OP_CLR_A, TCBS_OP_CLRLD_A, TCBS_OP_LD_A,
    TCBS_OP_SKIP, TCBS_OP_RD_B, TCBS_OP_LD_B
  } tcbs_op_e;
  typedef enum logic [2:0] {
    TCBS_B_IDLE, TCBS_B_CNT_RD, TCBS_B_CNT_WR, TCBS_B_PTR_RD, TCBS_B_PTR_WR, TCBS_B_DAT
  } tcbs_brk_e;
  typedef struct packed {
    logic       stb;
    tcbs_op_e   op;
    logic [11:0] ac;
  } tcbs_pio_req_s;
  typedef struct packed {
    logic       done;
    logic       skip;
    logic [11:0] rdata;
  } tcbs_pio_rsp_s;
  typedef struct packed {
    logic       req;
    logic       wr;
    logic [14:0] addr;
    logic [11:0] wdata;
  } tcbs_brk_s;
  typedef struct packed {
    logic       track_write_setting_sw;
    logic [7:0] end_zone;
    logic       chk_zone;
    logic       data_zone;
    logic       blknum_zone;
    logic [2:0] line;
    logic       line_stb;
  } tcbs_pins_s;
endpackage

// ===== core/tcbs_sequencer.sv
// tape control sequencer with three-cycle break channel and status registers
//
// Functional notes
// [RULE1] count at 7754, pointer at 7755, field 0
// [RULE2] mode bit taken on status load
// [RULE3] format mode: tape format alone gates transfers
// [RULE4] counted mode also gates on transfer count
// [RULE5] one of seven functions by code
// [RULE6] move: no mark decoding except end zone
// [RULE7] search: transfer block number; flag on overflow
// [RULE8] search flag: each block, or at zero
// [RULE9] search stores at pointer, no increment
// [RULE10] read data: flag at block end
// [RULE11] read all: every line; flag per word/overflow
// [RULE12] write data: zeros after overflow, then checksum
// [RULE13] write all flags like read all
// [RULE14] timing-mark write needs switch enabled
// [RULE15] switch plus function routes channel one to mark
// [RULE16] first register: unit, motion, mode, function, flags
// [RULE17] second register: field bits extend addresses
// [RULE18] pointer incremented before each data transfer
// [RULE19] data request flag per ready word
// [RULE20] six-bit check character written and verified
// [RULE21] end zone stops only selected transport
// [RULE22] processor answers a break within 17 us
// [RULE23] timing error when break not answered
// [RULE24] select error on function code 111
// [RULE25] count increments; overflow on wrap to zero
`include "tcbs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tcbs_sequencer (
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  input  wire logic                    ce,
  input  wire tcbs_pkg::tcbs_pio_req_s pio_req,
  output var  tcbs_pkg::tcbs_pio_rsp_s pio_rsp_q,
  input  wire logic                    brk_ack,
  input  wire logic [11:0]             brk_rdata,
  output var  tcbs_pkg::tcbs_brk_s     brk_q,
  input  wire tcbs_pkg::tcbs_pins_s    tp_pins,
  output var  logic [2:0]              unit_sel_q,
  output var  logic [7:0]              go_q,
  output var  logic [7:0]              dir_q,
  output var  logic                    wr_en_q,
  output var  logic [2:0]              wr_line_q,
  output var  logic                    mark_route_q,
  output var  logic                    irq_q
);
  tcbs_pkg::tcbs_pins_s   pin_m_q;
  tcbs_pkg::tcbs_pins_s   pin_s_q;
  tcbs_pkg::tcbs_brk_e    st_q;
  tcbs_pkg::tcbs_func_e   func;
  logic [11:0]            sa_q;
  logic [2:0]             field_q;
  logic                   stb_d_q;
  logic                   chk_d_q;
  logic                   done_q;
  logic                   drq_q;
  logic                   endz_q;
  logic                   sel_q;
  logic                   par_q;
  logic                   tim_q;
  logic                   sel_chk_q;
  logic                   ovf_q;
  logic                   ovf_now_q;
  logic                   to_mem_q;
  logic                   no_inc_q;
  logic [11:0]            xword_q;
  logic [`TCBS_TMO_W-1:0] tmo_q;
  logic [11:0]            word;
  logic                   word_stb;
  logic [5:0]             chk;

  // address of a break cycle: field bits over a 12-bit word address
  function automatic logic [14:0] mem_addr(input logic [2:0] fld, input logic [11:0] a);
    mem_addr = {fld, a};
  endfunction

  // tape pins are foreign: two flops, edge taken off the second stage
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      stb_d_q <= 1'b0;
      chk_d_q <= 1'b0;
    end
    else if (ce)
    begin
      pin_m_q <= tp_pins;
      pin_s_q <= pin_m_q;
      stb_d_q <= pin_s_q.line_stb;
      chk_d_q <= pin_s_q.chk_zone;
    end
  end

  // command decode and format zones
  wire       cm       = sa_q[`TCBS_A_MODE]; // RULE2 RULE4
  wire [2:0] unit     = sa_q[`TCBS_A_UNIT];
  wire       line_stb = pin_s_q.line_stb && !stb_d_q;
  wire       is_move  = func == tcbs_pkg::TCBS_F_MOVE;
  wire       blk_z    = pin_s_q.blknum_zone && !is_move; // RULE6
  wire       dat_z    = pin_s_q.data_zone && !is_move; // RULE6
  wire       chk_z    = pin_s_q.chk_zone && !is_move; // RULE6
  wire       endz     = pin_s_q.end_zone[unit] && go_q[unit]; // RULE21
  wire       blk_end  = chk_d_q && !pin_s_q.chk_zone && !is_move; // falling check zone
  wire       sw_on    = pin_s_q.track_write_setting_sw;
  wire       xfer_ok  = !(cm && ovf_q); // RULE4 RULE10
  wire       err_any  = endz_q | sel_q | par_q | tim_q;
  wire       idle     = st_q == tcbs_pkg::TCBS_B_IDLE;
  wire       pio_go   = pio_req.stb;
  wire       ld_a     = pio_go && (pio_req.op == tcbs_pkg::TCBS_OP_LD_A ||
                                   pio_req.op == tcbs_pkg::TCBS_OP_CLRLD_A);
  wire       clr_a    = pio_go && pio_req.op == tcbs_pkg::TCBS_OP_CLR_A;
  wire       ld_b     = pio_go && pio_req.op == tcbs_pkg::TCBS_OP_LD_B;
  wire [11:0] a_base  = (pio_req.op == tcbs_pkg::TCBS_OP_CLRLD_A) ? `TCBS_A_RESET : sa_q;
  wire [11:0] a_new   = a_base ^ (pio_req.ac & `TCBS_A_LOAD_MASK); // RULE2 RULE16
  wire [11:0] sb_view;
  assign func = tcbs_pkg::tcbs_func_e'(sa_q[`TCBS_A_FUNC]); // RULE5

  // second register image: errors, field, flags
  assign sb_view = {err_any, 1'b0, endz_q, sel_q, par_q, tim_q, field_q,
                    1'b0, drq_q, done_q}; // RULE17

  // function steering: which word boundary starts a break, loads, checks
  logic is_wr;
  logic start;
  logic ld_zero;
  logic ld_chk;
  logic acc_rd;
  logic par_chk;
  logic flag_per_xfer;
  logic flag_blk_end;
  always_comb
  begin
    is_wr = 1'b0;
    start = 1'b0;
    ld_zero = 1'b0;
    ld_chk = 1'b0;
    acc_rd = 1'b0;
    par_chk = 1'b0;
    flag_per_xfer = 1'b0;
    flag_blk_end = 1'b0;
    unique case (func)
      tcbs_pkg::TCBS_F_MOVE: ; // RULE6
      tcbs_pkg::TCBS_F_SEARCH:
      begin
        start = word_stb && blk_z; // RULE7
        flag_per_xfer = 1'b1; // RULE8
      end
      tcbs_pkg::TCBS_F_RD_DATA:
      begin
        start = word_stb && dat_z && xfer_ok; // RULE3 RULE10
        acc_rd = word_stb && dat_z; // RULE20
        par_chk = word_stb && chk_z; // RULE20
        flag_blk_end = 1'b1; // RULE10
      end
      tcbs_pkg::TCBS_F_RD_ALL:
      begin
        start = word_stb && xfer_ok; // RULE11
        flag_per_xfer = 1'b1; // RULE11
      end
      tcbs_pkg::TCBS_F_WR_DATA:
      begin
        is_wr = 1'b1;
        start = word_stb && dat_z && xfer_ok;
        ld_zero = word_stb && dat_z && !xfer_ok; // RULE12
        ld_chk = word_stb && chk_z; // RULE12 RULE20
        flag_blk_end = 1'b1; // RULE12
      end
      tcbs_pkg::TCBS_F_WR_ALL, tcbs_pkg::TCBS_F_WR_TM:
      begin
        is_wr = 1'b1;
        start = word_stb && xfer_ok;
        ld_zero = word_stb && !xfer_ok;
        flag_per_xfer = 1'b1; // RULE13 RULE14
      end
      default: ; // code 111 does nothing but raise a select error
    endcase
  end

  // break sequencer handshakes
  wire ack_cnt_rd = brk_ack && st_q == tcbs_pkg::TCBS_B_CNT_RD;
  wire ack_ptr_rd = brk_ack && st_q == tcbs_pkg::TCBS_B_PTR_RD;
  wire ack_dat    = brk_ack && st_q == tcbs_pkg::TCBS_B_DAT;
  wire [11:0] cnt_inc = brk_rdata + 12'h001; // RULE25
  wire new_start  = start && idle;
  wire ld_data    = ack_dat && !to_mem_q;
  wire done_set   = (ack_dat && flag_per_xfer && (!cm || ovf_now_q)) ||
                    (blk_end && flag_blk_end && (!cm || ovf_q)); // RULE8 RULE10 RULE11
  wire lost_word  = start && !idle; // a word came before the last break ended

  // three-cycle break: count, pointer, data
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_q <= tcbs_pkg::TCBS_B_IDLE;
      brk_q <= '0;
      to_mem_q <= 1'b0;
      no_inc_q <= 1'b0;
      xword_q <= 12'h000;
      ovf_now_q <= 1'b0;
    end
    else if (ce)
    begin
      unique case (st_q)
        tcbs_pkg::TCBS_B_IDLE:
          if (new_start)
          begin
            st_q <= tcbs_pkg::TCBS_B_CNT_RD;
            brk_q <= '{req: 1'b1, wr: 1'b0, wdata: 12'h000,
                       addr: mem_addr(`TCBS_FIELD0, `TCBS_CNT_ADDR)}; // RULE1
            to_mem_q <= !is_wr;
            no_inc_q <= func == tcbs_pkg::TCBS_F_SEARCH; // RULE9
            xword_q <= word;
          end
        tcbs_pkg::TCBS_B_CNT_RD:
          if (brk_ack)
          begin
            st_q <= tcbs_pkg::TCBS_B_CNT_WR;
            brk_q.wr <= 1'b1;
            brk_q.wdata <= cnt_inc; // RULE25
            ovf_now_q <= cnt_inc == 12'h000; // RULE25
          end
        tcbs_pkg::TCBS_B_CNT_WR:
          if (brk_ack)
          begin
            st_q <= tcbs_pkg::TCBS_B_PTR_RD;
            brk_q.wr <= 1'b0;
            brk_q.addr <= mem_addr(`TCBS_FIELD0, `TCBS_PTR_ADDR); // RULE1
          end
        tcbs_pkg::TCBS_B_PTR_RD:
          if (brk_ack && no_inc_q)
          begin
            st_q <= tcbs_pkg::TCBS_B_DAT;
            brk_q <= '{req: 1'b1, wr: to_mem_q, wdata: xword_q,
                       addr: mem_addr(field_q, brk_rdata)}; // RULE9 RULE17
          end
          else if (brk_ack)
          begin
            st_q <= tcbs_pkg::TCBS_B_PTR_WR;
            brk_q.wr <= 1'b1;
            brk_q.wdata <= brk_rdata + 12'h001; // RULE18
          end
        tcbs_pkg::TCBS_B_PTR_WR:
          if (brk_ack)
          begin
            st_q <= tcbs_pkg::TCBS_B_DAT;
            brk_q <= '{req: 1'b1, wr: to_mem_q, wdata: xword_q,
                       addr: mem_addr(field_q, brk_q.wdata)}; // RULE17 RULE18
          end
        tcbs_pkg::TCBS_B_DAT:
          if (brk_ack)
          begin
            st_q <= tcbs_pkg::TCBS_B_IDLE;
            brk_q <= '0;
          end
        default: st_q <= tcbs_pkg::TCBS_B_IDLE;
      endcase
    end
  end

  // answer timer: runs only while the first cycle waits; holds while ce is low
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      tmo_q <= '0;
    else if (ce)
    begin
      if (st_q != tcbs_pkg::TCBS_B_CNT_RD)
        tmo_q <= '0;
      else if (tmo_q != `TCBS_TMO_W'(`TCBS_BRK_TMO_CYC))
        tmo_q <= tmo_q + 1'b1;
    end
  end
  wire tmo_hit = tmo_q == `TCBS_TMO_W'(`TCBS_BRK_TMO_CYC) - 1'b1; // RULE23

  // select error: illegal code or switch and function disagree
  wire sel_bad = (sa_q[`TCBS_A_FUNC] == 3'h7) || // RULE24
                 (sw_on != (func == tcbs_pkg::TCBS_F_WR_TM)); // RULE14
  wire stop_sel = endz || (sel_chk_q && sel_bad) || tmo_hit; // RULE21

  // status registers and flags; hardware set wins over software clear
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sa_q <= `TCBS_A_RESET;
      field_q <= `TCBS_FIELD0;
      go_q <= 8'h00;
      dir_q <= 8'h00;
      done_q <= 1'b0;
      drq_q <= 1'b0;
      endz_q <= 1'b0;
      sel_q <= 1'b0;
      par_q <= 1'b0;
      tim_q <= 1'b0;
      ovf_q <= 1'b0;
      sel_chk_q <= 1'b0;
    end
    else if (ce)
    begin
      sel_chk_q <= ld_a;
      if (ld_a)
      begin
        sa_q <= a_new; // RULE16
        go_q[a_new[`TCBS_A_UNIT]] <= a_new[`TCBS_A_GO];
        dir_q[a_new[`TCBS_A_UNIT]] <= a_new[`TCBS_A_DIR];
        ovf_q <= 1'b0;
      end
      else if (clr_a)
      begin
        sa_q <= `TCBS_A_RESET;
        go_q[unit] <= 1'b0;
      end
      else if (stop_sel)
        go_q[unit] <= 1'b0; // RULE21
      if (ld_b)
        field_q <= pio_req.ac[`TCBS_B_FIELD]; // RULE17
      if (ack_dat && ovf_now_q)
        ovf_q <= 1'b1; // RULE10
      drq_q <= new_start || (drq_q && !ack_dat); // RULE19
      done_q <= done_set || (done_q && !(ld_a && pio_req.ac[`TCBS_A_CLR_DONE]));
      endz_q <= endz || (endz_q && !(ld_a && pio_req.ac[`TCBS_A_CLR_ERR])); // RULE21
      sel_q <= (sel_chk_q && sel_bad) || (sel_q && !(ld_a && pio_req.ac[`TCBS_A_CLR_ERR]));
      par_q <= (par_chk && word[5:0] != chk) ||
               (par_q && !(ld_a && pio_req.ac[`TCBS_A_CLR_ERR])); // RULE20
      tim_q <= tmo_hit || lost_word || (done_set && done_q) ||
               (tim_q && !(ld_a && pio_req.ac[`TCBS_A_CLR_ERR])); // RULE23
    end
  end

  // programmed I/O answers and pin-facing outputs
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pio_rsp_q <= '0;
      unit_sel_q <= 3'h0;
      wr_en_q <= 1'b0;
      mark_route_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      pio_rsp_q.done <= pio_go;
      pio_rsp_q.skip <= pio_go && pio_req.op == tcbs_pkg::TCBS_OP_SKIP && (done_q || err_any);
      pio_rsp_q.rdata <= !pio_go ? 12'h000 :
        pio_req.op == tcbs_pkg::TCBS_OP_RD_A ? (sa_q | (pio_req.ac & `TCBS_A_LOAD_MASK)) :
        pio_req.op == tcbs_pkg::TCBS_OP_RD_B ? (sb_view | pio_req.ac) :
        pio_req.op == tcbs_pkg::TCBS_OP_SKIP ? pio_req.ac : 12'h000;
      unit_sel_q <= unit;
      wr_en_q <= is_wr && go_q[unit] && !(func == tcbs_pkg::TCBS_F_WR_TM && !sw_on);
      mark_route_q <= sw_on && func == tcbs_pkg::TCBS_F_WR_TM; // RULE15
      irq_q <= sa_q[`TCBS_A_IE] && (done_q || err_any);
    end
  end

  // line shifter: read words out, write words in; check over data words
  tcbs_line_packer u_packer (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .ce         (ce),
    .line_stb   (line_stb && go_q[unit]),
    .line_in    (pin_s_q.line),
    .wr_mode    (is_wr),
    .load       (ld_data || ld_zero || ld_chk),
    .load_word  (ld_data ? brk_rdata : ld_chk ? {6'h00, chk} : 12'h000), // RULE12
    .acc_stb    (acc_rd || (ld_data && func == tcbs_pkg::TCBS_F_WR_DATA && dat_z)),
    .acc_clr    (blk_end || ld_a),
    .acc_word   (acc_rd ? word : brk_rdata),
    .word_q     (word),
    .word_stb_q (word_stb),
    .line_out_q (wr_line_q),
    .chk_q      (chk)
  );

  // checks next to the logic
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst || !ce);
  sequence s_cnt_answer;
    st_q == tcbs_pkg::TCBS_B_CNT_RD && brk_ack;
  endsequence
  sequence s_break_open;
    idle && new_start;
  endsequence
  a_cnt_first_addr: assert property (s_break_open |=> brk_q.req && !brk_q.wr && // RULE1
    brk_q.addr == {`TCBS_FIELD0, `TCBS_CNT_ADDR})
    else $error("break did not open on the count word");
  a_ptr_addr_next: assert property (st_q == tcbs_pkg::TCBS_B_CNT_WR && brk_ack |=> // RULE1
    brk_q.addr == {`TCBS_FIELD0, `TCBS_PTR_ADDR} && !brk_q.wr)
    else $error("pointer word address wrong");
  a_cnt_incr_wrap: assert property (s_cnt_answer |=> brk_q.wr && // RULE25
    brk_q.wdata == $past(brk_rdata) + 12'h001 && ovf_now_q == ($past(brk_rdata) == 12'hfff))
    else $error("count not incremented");
  a_mode_on_load: assert property (ld_a && pio_req.op == tcbs_pkg::TCBS_OP_LD_A |=> // RULE2
    cm == ($past(sa_q[`TCBS_A_MODE]) ^ $past(pio_req.ac[`TCBS_A_MODE])))
    else $error("mode bit not loaded");
  a_search_no_inc: assert property (ack_ptr_rd && no_inc_q |=> // RULE9
    st_q == tcbs_pkg::TCBS_B_DAT && brk_q.addr[11:0] == $past(brk_rdata))
    else $error("search moved the pointer");
  a_ptr_pre_inc: assert property (ack_ptr_rd && !no_inc_q |=> // RULE18
    brk_q.wr && brk_q.wdata == $past(brk_rdata) + 12'h001)
    else $error("pointer not pre-incremented");
  a_drq_on_word: assert property (s_break_open |=> drq_q throughout // RULE19
    (st_q != tcbs_pkg::TCBS_B_IDLE)[*2])
    else $error("data request flag missing");
  a_illegal_code: assert property (ld_a && a_new[`TCBS_A_FUNC] == 3'h7 |=> ##1 sel_q) // RULE24
    else $error("code 111 did not raise select error");
  a_break_timeout: assert property (tmo_hit |=> tim_q && !go_q[$past(unit)]) // RULE23
    else $error("unanswered break not flagged");
  a_mark_route: assert property (mark_route_q |-> // RULE15
    $past(sw_on) && $past(func) == tcbs_pkg::TCBS_F_WR_TM)
    else $error("mark channel routed wrongly");
  a_endz_stop: assert property (endz |=> !go_q[$past(unit)] && endz_q) // RULE21
    else $error("end zone did not stop selected unit");
  a_move_quiet: assert property (is_move |-> !new_start && !done_set) // RULE6
    else $error("move function transferred data");
endmodule
`default_nettype wire
